//--- rtl/ccd_front_end.sv
/*
 * Digital side of a linear image-sensor front end: dual sampling, offset DAC,
 * coarse and per-pixel gain, offset add, 8-bit result with done strobe and read control.
 * Assumes the controller drives the correction bus and register port synchronously to mclk.
 */
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ps
module ccd_front_end #(
	parameter int SAMPLE_W = 12
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [SAMPLE_W-1:0] sensor_analog_in,
	input wire logic [7:0] gain_coef_bus,
	input wire logic result_read_n,
	output logic [7:0] result_out,
	output logic result_oe,
	output logic conv_done_n,
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata
);

	// ********************************************************
	// Configuration registers
	// ********************************************************
	logic [7:0] config_reg;
	logic [4:0] offset_dac;
	logic [3:0] coarse_gain;
	logic [2:0] phase;
	logic [7:0] pixel_gain;
	logic [SAMPLE_W+2:0] ref_held;
	logic [SAMPLE_W+2:0] sig_held;

	wire polarity_neg = config_reg[ccd_front_pkg::POLARITY_BIT];
	wire offset_add = config_reg[ccd_front_pkg::OFFSET_ADD_BIT];
	wire [1:0] ref_pos = config_reg[ccd_front_pkg::REF_POS_LSB +: 2];
	wire [1:0] sig_pos = config_reg[ccd_front_pkg::SIG_POS_LSB +: 2];

	// Offset DAC and coarse gain are written at configuration time only
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			config_reg <= ccd_front_pkg::CONFIG_RESET;
			offset_dac <= ccd_front_pkg::OFFSET_DAC_RESET;
			coarse_gain <= ccd_front_pkg::COARSE_GAIN_RESET;
		end else if (reg_wr) begin
			if (reg_addr == ccd_front_pkg::CONFIG_OFS) config_reg <= reg_wdata;
			if (reg_addr == ccd_front_pkg::OFFSET_DAC_OFS) offset_dac <= reg_wdata[4:0];
			if (reg_addr == ccd_front_pkg::COARSE_GAIN_OFS) coarse_gain <= reg_wdata[3:0];
		end
	end

	// Read decode; every address is mapped
	wire [7:0] next_rdata =
		(reg_addr == ccd_front_pkg::CONFIG_OFS) ? config_reg :
		(reg_addr == ccd_front_pkg::OFFSET_DAC_OFS) ? {3'h0, offset_dac} :
		(reg_addr == ccd_front_pkg::COARSE_GAIN_OFS) ? {4'h0, coarse_gain} :
		result_out;

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= reg_rd ? next_rdata : 8'h00;
		end
	end

	// ********************************************************
	// Pixel timing and sampling
	// ********************************************************
	// Eight master clocks per pixel
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			phase <= 3'h0;
		end else begin
			phase <= phase + 3'h1;
		end
	end

	// Aperture start in coarse steps; the step is the 25 ns grain rounded to clocks
	wire [2:0] ref_start = 3'(int'(ref_pos) * ccd_front_pkg::STEP_CYC);
	wire [2:0] sig_start = 3'(int'(sig_pos) * ccd_front_pkg::STEP_CYC);

	aperture_capture #(.SAMPLE_W(SAMPLE_W)) ref_capture (
		.mclk(mclk),
		.rstn(rstn),
		.phase(phase),
		.start(ref_start),
		.sample(sensor_analog_in),
		.held(ref_held)
	);

	aperture_capture #(.SAMPLE_W(SAMPLE_W)) sig_capture (
		.mclk(mclk),
		.rstn(rstn),
		.phase(phase),
		.start(sig_start),
		.sample(sensor_analog_in),
		.held(sig_held)
	);

	// Coefficient taken late in the pixel, while the done strobe is high
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pixel_gain <= 8'h00;
		end else if (phase == ccd_front_pkg::GAIN_SAMPLE_PHASE) begin
			pixel_gain <= gain_coef_bus;
		end
	end

	// ********************************************************
	// Signal chain, in hundredths of an LSB
	// ********************************************************
	// Samples are quarter LSBs summed over the aperture; scale to an average
	wire signed [31:0] ref_centi =
		(32'(ref_held) * ccd_front_pkg::CENTI_PER_QUARTER) / ccd_front_pkg::APERTURE_CYC;
	wire signed [31:0] sig_centi =
		(32'(sig_held) * ccd_front_pkg::CENTI_PER_QUARTER) / ccd_front_pkg::APERTURE_CYC;
	// Negative-going sensors fall below the reference level
	wire signed [31:0] cds_diff = polarity_neg ? ref_centi - sig_centi : sig_centi - ref_centi;
	wire signed [31:0] coarse_q8 = 32'(ccd_front_pkg::coarse_gain_q8(coarse_gain));
	wire signed [31:0] coarse_out = (cds_diff * coarse_q8) >>> 8;
	wire signed [31:0] dac_mag = 32'(offset_dac[3:0]) * ccd_front_pkg::DAC_STEP_CENTI;
	wire signed [31:0] dac_centi = offset_dac[ccd_front_pkg::DAC_SIGN_BIT] ? -dac_mag : dac_mag;
	// DAC sits after coarse gain and ahead of the pixel gain stage, so its residue is scaled with the pixel
	wire signed [31:0] pre_gain = coarse_out + dac_centi;
	wire signed [31:0] pga_q8 = ccd_front_pkg::UNITY_Q8 +
		((32'(pixel_gain) * ccd_front_pkg::PGA_SLOPE_Q8) >>> 8);
	wire signed [31:0] post_gain = (pre_gain * pga_q8) >>> 8;
	wire signed [31:0] post_add = post_gain + (offset_add ? ccd_front_pkg::OFFSET_ADD_CENTI : 0);
	wire signed [31:0] rounded = (post_add + ccd_front_pkg::CENTI_PER_LSB / 2) /
		ccd_front_pkg::CENTI_PER_LSB;
	// Clip rather than wrap: dark values below zero read as code 0
	wire [7:0] next_result = (post_add < 0) ? 8'h00 :
		(rounded > ccd_front_pkg::RESULT_MAX) ? 8'hff : rounded[7:0];

	// ********************************************************
	// Result, done strobe and bus drive
	// ********************************************************
	// Result loads at pixel end; done falls with it and rises half a pixel later
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			result_out <= 8'h00;
			conv_done_n <= 1'b1;
		end else if (phase == ccd_front_pkg::PIXEL_LAST) begin
			result_out <= next_result;
			conv_done_n <= 1'b0;
		end else if (phase == ccd_front_pkg::DONE_RISE_PHASE) begin
			conv_done_n <= 1'b1;
		end
	end

	// Bus enable follows the read input one clock later, keeping the output registered
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			result_oe <= 1'b0;
		end else begin
			result_oe <= ~result_read_n;
		end
	end

endmodule : ccd_front_end

//--- pkg/ccd_front_pkg.sv
/*
 * Constants, register map and helper functions for the sensor front-end readout block.
 * Assumes one 125 MHz master clock and a synchronous controller on the far side.
 */
// Behaviour
// - Each of two sampling captures has a fixed aperture, placed within the pixel in steps.
// - Polarity bit clear takes positive-going input, set takes negative-going input.
// - Offset DAC is sign plus four magnitude bits, 31 steps of 0.42 LSB.
// - Offset DAC acts before the pixel gain stage, so residue is multiplied by gain.
// - Per-pixel gain is one plus code over 256 times 1.95, code from correction bus.
// - Offset-add bit set adds two LSB after the pixel gain stage; clear adds nothing.
// - Each pixel yields an 8-bit result; active-low done output falls when it is ready.
// - Active-low read input drives the result bus only while low, released otherwise; here the enable follows read one clock late.
// - With read tied to done, controller drives coefficients only while done is high.
// - One pixel converts every eight master clocks, pacing strobes and coefficients.
package ccd_front_pkg;

	// ********************************************************
	// Timing
	// ********************************************************
	localparam int CLK_PERIOD_NS = 8;
	localparam int PIXEL_CYC = 8;
	localparam logic [2:0] PIXEL_LAST = 3'h7;
	localparam logic [2:0] GAIN_SAMPLE_PHASE = 3'h6;
	localparam logic [2:0] DONE_RISE_PHASE = 3'h3;
	localparam int APERTURE_NS = 50;
	localparam int APERTURE_CYC = APERTURE_NS / CLK_PERIOD_NS;
	localparam logic [2:0] APERTURE_LAST = 3'(APERTURE_CYC - 1);
	localparam int STEP_NS = 25;
	localparam int STEP_CYC = STEP_NS / CLK_PERIOD_NS;

	// ********************************************************
	// Register map and reset values
	// ********************************************************
	localparam logic [1:0] CONFIG_OFS = 2'h0;
	localparam logic [1:0] OFFSET_DAC_OFS = 2'h1;
	localparam logic [1:0] COARSE_GAIN_OFS = 2'h2;
	localparam logic [1:0] LAST_RESULT_OFS = 2'h3;
	localparam int POLARITY_BIT = 0;
	localparam int OFFSET_ADD_BIT = 1;
	localparam int REF_POS_LSB = 2;
	localparam int SIG_POS_LSB = 4;
	localparam int DAC_SIGN_BIT = 4;
	localparam logic [7:0] CONFIG_RESET = 8'h10;
	localparam logic [4:0] OFFSET_DAC_RESET = 5'h00;
	localparam logic [3:0] COARSE_GAIN_RESET = 4'h0;

	// ********************************************************
	// Arithmetic: levels in hundredths of a converter LSB, gain factors as Q8
	// ********************************************************
	localparam int CENTI_PER_LSB = 100;
	localparam int CENTI_PER_QUARTER = 25;
	localparam int DAC_STEP_CENTI = 42;
	localparam int OFFSET_ADD_CENTI = 200;
	localparam int PGA_SLOPE_Q8 = 499;
	localparam int UNITY_Q8 = 256;
	localparam int RESULT_MAX = 255;

	// Coarse gain 0 to 8.95 dB over sixteen codes, as a Q8 factor
	function automatic logic [9:0] coarse_gain_q8(input logic [3:0] code);
		logic [9:0] g;
		unique case (code)
			4'h0: g = 10'h100;
			4'h1: g = 10'h112;
			4'h2: g = 10'h126;
			4'h3: g = 10'h13b;
			4'h4: g = 10'h151;
			4'h5: g = 10'h169;
			4'h6: g = 10'h183;
			4'h7: g = 10'h19e;
			4'h8: g = 10'h1bc;
			4'h9: g = 10'h1db;
			4'ha: g = 10'h1fd;
			4'hb: g = 10'h221;
			4'hc: g = 10'h248;
			4'hd: g = 10'h271;
			4'he: g = 10'h29e;
			4'hf: g = 10'h2cd;
		endcase
		return g;
	endfunction : coarse_gain_q8

endpackage : ccd_front_pkg

//--- rtl/aperture_capture.sv
/*
 * One sampling capture: sums the input over a fixed aperture starting at a chosen phase.
 * Assumes phase counts 0..7 per pixel and samples are synchronous to mclk.
 */
`timescale 1ns/1ps
module aperture_capture #(
	parameter int SAMPLE_W = 12
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [2:0] phase,
	input wire logic [2:0] start,
	input wire logic [SAMPLE_W-1:0] sample,
	output logic [SAMPLE_W+2:0] held
);

	// ********************************************************
	// Window decode
	// ********************************************************
	// Offset wraps modulo the pixel, so a window may straddle a pixel boundary
	wire [2:0] offset = phase - start;
	wire in_win = offset <= ccd_front_pkg::APERTURE_LAST;
	wire last = offset == ccd_front_pkg::APERTURE_LAST;
	wire [SAMPLE_W+2:0] wide = {3'h0, sample};
	logic [SAMPLE_W+2:0] acc;
	wire [SAMPLE_W+2:0] sum = (offset == 3'h0) ? wide : acc + wide;

	// Accumulate inside the aperture and hold the total until the next window ends
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			acc <= '0;
			held <= '0;
		end else if (in_win) begin
			acc <= sum;
			if (last) begin
				held <= sum;
			end
		end
	end

endmodule : aperture_capture

//--- sim/ccd_front_properties.sv
/* Checker for the pixel stream, read control and register port.
   Bound to ccd_front_end; sees only its ports. */
`timescale 1ns/1ps
module ccd_front_checker (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic result_read_n,
	input wire logic [7:0] result_out,
	input wire logic result_oe,
	input wire logic conv_done_n,
	input wire logic [1:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata
);
	// ****
	// Properties
	// ****
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	// Strobe shape: four low, four high, one pixel every eight clocks
	sequence done_fall; $fell(conv_done_n); endsequence
	sequence low_run; (!conv_done_n) [*3] ##1 conv_done_n; endsequence
	sequence high_run; conv_done_n [*3] ##1 !conv_done_n; endsequence
	done_low_a: assert property (done_fall |=> low_run)
		else $error("done strobe low width wrong");
	done_high_a: assert property ($rose(conv_done_n) |=> high_run)
		else $error("done strobe high width wrong");
	pixel_period_a: assert property (done_fall |-> ##8 $fell(conv_done_n))
		else $error("pixel period not eight clocks");
	result_hold_a: assert property (!$fell(conv_done_n) |-> $stable(result_out))
		else $error("result moved without a new strobe");
	// First edge after reset is skipped: the enable is cleared there by design
	oe_follows_a: assert property ($past(rstn) |-> result_oe == !$past(result_read_n))
		else $error("output enable does not follow read");
	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside read slot");
	coarse_bits_a: assert property (reg_rd && reg_addr == ccd_front_pkg::COARSE_GAIN_OFS
		|=> reg_rdata[7:4] == 4'h0) else $error("coarse unused bits not zero");
	dac_code_a: assert property (reg_rd && reg_addr == ccd_front_pkg::OFFSET_DAC_OFS
		|=> reg_rdata[7:5] == 3'h0) else $error("offset code wider than five bits");
	// Only read while the strobe is low, so the result cannot move under the read
	last_result_a: assert property (reg_rd && reg_addr == ccd_front_pkg::LAST_RESULT_OFS
		&& !conv_done_n |=> reg_rdata == result_out) else $error("last result mismatch");
endmodule : ccd_front_checker

bind ccd_front_end ccd_front_checker u_chk (.mclk(mclk), .rstn(rstn),
	.result_read_n(result_read_n), .result_out(result_out), .result_oe(result_oe),
	.conv_done_n(conv_done_n), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

//--- sim/scanner_ctrl_model.sv
/* Scanner controller model on the coefficient bus and result strobe.
   Assumes read is tied to the done strobe, so the bus is shared. */
`timescale 1ns/1ps
module scanner_ctrl_model (
	input wire logic conv_done_n,
	input wire logic [7:0] result_out,
	input wire logic [7:0] coef,
	output logic [7:0] gain_coef_bus,
	output logic [7:0] latched
);
	// Code only while the strobe is high; inverted junk otherwise exposes late sampling
	assign gain_coef_bus = conv_done_n ? coef : ~coef;
	// Latch as an external memory would, on the trailing edge of the strobe
	always_ff @(posedge conv_done_n) begin
		latched <= result_out;
	end
endmodule : scanner_ctrl_model

//--- sim/testbench.sv
/* Self-checking bench for ccd_front_end with the controller model.
   Assumes a flat input level, so both captures match and only offsets show,
   except where the polarity scenario places a dip at phases 6 and 7. */
`timescale 1ns/1ps
module testbench;
	logic mclk, rstn, reg_wr, reg_rd, result_oe, conv_done_n;
	logic [1:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, result_out, gain_coef_bus, coef, latched;
	int n_fail, checked;
	logic dip_on;
	logic [2:0] bench_phase;
	logic [11:0] sensor;
	// ****
	// Instances and clock
	// ****
	ccd_front_end u_dut (.mclk(mclk), .rstn(rstn), .sensor_analog_in(sensor),
		.gain_coef_bus(gain_coef_bus), .result_read_n(conv_done_n), .result_out(result_out),
		.result_oe(result_oe), .conv_done_n(conv_done_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	scanner_ctrl_model u_ctrl (.conv_done_n(conv_done_n), .result_out(result_out),
		.coef(coef), .gain_coef_bus(gain_coef_bus), .latched(latched));
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	// Mirrors the pixel phase; the level for the next phase is driven on the edge before it
	wire dip_next = dip_on && (bench_phase == 3'h5 || bench_phase == 3'h6);
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			bench_phase <= 3'h0;
			sensor <= 12'h200;
		end else begin
			bench_phase <= bench_phase + 3'h1;
			sensor <= dip_next ? 12'h188 : 12'h200;
		end
	end
	// ****
	// Tasks
	// ****
	task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk8
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [1:0] a, input logic [7:0] exp, input string what);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 chk8(what, exp, reg_rdata);
	endtask : rd
	// Four pixels let a new setting pass the whole chain before judging
	task automatic pix(input logic [7:0] c, input logic [7:0] exp, input string what);
		@(posedge mclk);
		coef <= c;
		repeat (32) @(posedge mclk);
		#1 chk8(what, exp, latched);
		rd(ccd_front_pkg::LAST_RESULT_OFS, exp, "last result");
	endtask : pix
	// One black line of eight pixels, averaged as the controller stores it
	task automatic black_line(input logic [7:0] c, output int avg);
		int sum;
		sum = 0;
		@(posedge mclk);
		coef <= c;
		repeat (32) @(posedge mclk);
		repeat (8) begin
			@(posedge conv_done_n);
			#1 sum += int'(latched);
		end
		avg = sum / 8;
	endtask : black_line
	task automatic t_regs();
		rd(ccd_front_pkg::CONFIG_OFS, ccd_front_pkg::CONFIG_RESET, "config");
		rd(ccd_front_pkg::OFFSET_DAC_OFS, {3'h0, ccd_front_pkg::OFFSET_DAC_RESET}, "dac");
		wr(ccd_front_pkg::COARSE_GAIN_OFS, 8'hfa);
		rd(ccd_front_pkg::COARSE_GAIN_OFS, 8'h0a, "coarse");
		wr(ccd_front_pkg::COARSE_GAIN_OFS, 8'h00);
		wr(ccd_front_pkg::LAST_RESULT_OFS, 8'h5a);
		rd(ccd_front_pkg::LAST_RESULT_OFS, 8'h00, "read-only result");
	endtask : t_regs
	task automatic t_add();
		wr(ccd_front_pkg::CONFIG_OFS, 8'h12);
		pix(8'h00, 8'h02, "add on");
		wr(ccd_front_pkg::CONFIG_OFS, 8'h10);
		pix(8'h00, 8'h00, "add off");
	endtask : t_add
	// Full positive code is 630 hundredths; gain 753/256 at code 255
	task automatic t_gain();
		wr(ccd_front_pkg::OFFSET_DAC_OFS, 8'h0f);
		pix(8'h00, 8'h06, "unity gain");
		pix(8'hff, 8'h13, "max gain");
	endtask : t_gain
	task automatic t_neg();
		wr(ccd_front_pkg::CONFIG_OFS, 8'h12);
		wr(ccd_front_pkg::OFFSET_DAC_OFS, 8'h1f);
		pix(8'hff, 8'h00, "negative clamp");
	endtask : t_neg
	// Black offset calibration, then coarse gain, then coefficients, in that order
	task automatic t_cal();
		int first, second, code, resid;
		logic add;
		wr(ccd_front_pkg::CONFIG_OFS, 8'h10);
		wr(ccd_front_pkg::COARSE_GAIN_OFS, 8'h00);
		wr(ccd_front_pkg::OFFSET_DAC_OFS, 8'h0f);
		black_line(8'h00, first);
		black_line(8'hff, second);
		code = 15 + (39 * (first - second)) / 32;
		code = (code > 15) ? 15 : ((code < -15) ? -15 : code);
		add = (3 * first < second);
		resid = (3 * first - second) / 2 + (add ? 2 : 0);
		wr(ccd_front_pkg::OFFSET_DAC_OFS,
			(code < 0) ? {4'h1, 4'(-code)} : {4'h0, 4'(code)});
		wr(ccd_front_pkg::CONFIG_OFS, {6'h04, add, 1'b0});
		wr(ccd_front_pkg::COARSE_GAIN_OFS, 8'h00);
		pix(8'h00, 8'(resid), "residual unity");
		pix(8'hff, 8'(resid), "residual max gain");
	endtask : t_cal
	// A 30 LSB dip over 2 of the 6 aperture clocks averages to 10 LSB in the window holding it
	task automatic t_pol();
		wr(ccd_front_pkg::OFFSET_DAC_OFS, 8'h00);
		dip_on <= 1'b1;
		wr(ccd_front_pkg::CONFIG_OFS, 8'h21);
		pix(8'h00, 8'h0a, "negative-going");
		wr(ccd_front_pkg::CONFIG_OFS, 8'h20);
		pix(8'h00, 8'h00, "positive-going");
		wr(ccd_front_pkg::CONFIG_OFS, 8'h08);
		pix(8'h00, 8'h0a, "window moved");
		dip_on <= 1'b0;
	endtask : t_pol
	task automatic tally_and_finish();
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : tally_and_finish
	// ****
	// Sequence and watchdog
	// ****
	initial begin
		rstn = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 2'h0;
		reg_wdata = 8'h00;
		coef = 8'h00;
		dip_on = 1'b0;
		n_fail = 0;
		checked = 0;
		repeat (3) @(posedge mclk);
		rstn <= 1'b1;
		t_regs();
		t_add();
		t_gain();
		t_neg();
		t_cal();
		t_pol();
		tally_and_finish();
	end
	// About 590 clocks expected; over six times that means a hang
	initial begin
		repeat (4000) @(posedge mclk);
		n_fail++;
		tally_and_finish();
	end
endmodule : testbench
